// ### common/fts_map.vh
// Constants for the flow-through burst static memory port.
// Assumes inclusion by bare name from the design files under src/.
`ifndef FTS_MAP_VH
`define FTS_MAP_VH

// Array organisation: 512K words of 36 bits.
`define FTS_ADDR_W      19
`define FTS_DATA_W      36
`define FTS_LANES       4
`define FTS_LANE_W      9

// Burst counter width and the burst order strap encoding.
`define FTS_BURST_W     2
`define FTS_ORDER_LIN   1'b0
`define FTS_ORDER_ILV   1'b1

// Reset values of the control state.
`define FTS_CNT_RST     2'h0
`define FTS_DATA_RST    36'h0_0000_0000

`endif

// ### src/fts_burst_ctr.v
// Two-bit burst counter that produces the low address bits of each beat.
// Assumes the caller qualifies every update with the clock-qualify term.
`timescale 1ns/1ns
`include "fts_map.vh"

module fts_burst_ctr (
	// Clock and reset
	input  wire                    mclk_i,
	input  wire                    reset_i,
	// Control
	input  wire                    qual_i,
	input  wire                    load_i,
	input  wire                    adv_i,
	input  wire                    order_ilv_i,
	input  wire [`FTS_BURST_W-1:0] start_i,
	// Low address bits for the access in this cycle
	output reg  [`FTS_BURST_W-1:0] low_o
);

	reg [`FTS_BURST_W-1:0] start_reg;
	reg [`FTS_BURST_W-1:0] cnt_reg;
	reg [`FTS_BURST_W-1:0] cnt_next;

	always @* begin
		cnt_next = cnt_reg + `FTS_BURST_W'd1;
		if (load_i) begin
			low_o = start_i; // R12
		end else if (order_ilv_i == `FTS_ORDER_ILV) begin
			low_o = start_reg ^ cnt_next; // R10
		end else begin
			low_o = start_reg + cnt_next; // R10
		end
	end

	always @(posedge mclk_i) begin
		if (reset_i) begin
			start_reg <= `FTS_CNT_RST;
			cnt_reg   <= `FTS_CNT_RST;
		end else if (qual_i) begin // R3
			if (load_i) begin
				start_reg <= start_i; // R12
				cnt_reg   <= `FTS_CNT_RST;
			end else if (adv_i) begin
				cnt_reg <= cnt_next; // R13
			end
		end
	end

endmodule

// ### src/fts_port.v
// Flow-through burst static memory port, 512K x 36, with late-write data.
// Assumes all pin inputs but the output enable are synchronous to mclk_i; the bench resolves the
// data bus wire from dq_o and dq_oe_o.
//
// Functional notes
// (R1) Store 512K x 36; flow-through burst port.
// (R2) Act on inputs only at rising edges; the output enable gates the drivers without an edge.
// (R3) Clock-qualify inactive freezes all state.
// (R4) Back-to-back reads and writes, no idle cycles.
// (R5) Write strobe plus byte selects update lanes.
// (R6) Drivers off during write data phase.
// (R7) Output timing needs no output enable toggling.
// (R8) Output enable acts without a clock edge.
// (R9) Selected only with all three selects active.
// (R10) Linear or interleaved burst order by strap.
// (R11) Low power on sleep or deselect.
// (R12) Low two address bits load burst counter.
// (R13) Advance continues burst; low loads new address.
// (R14) Host drives write strobe low to write.
// (R15) Each byte select covers nine-bit lane.
// (R16) Read data appears in the access cycle.
`timescale 1ns/1ns
`include "fts_map.vh"

module fts_port #(
	parameter ADDR_W = `FTS_ADDR_W,
	parameter DATA_W = `FTS_DATA_W,
	parameter LANES  = `FTS_LANES,
	parameter LANE_W = `FTS_LANE_W
) (
	// Clock and reset
	input  wire              mclk_i,
	input  wire              reset_i,
	// Access control
	input  wire              clock_qualify_n_i,
	input  wire [ADDR_W-1:0] addr_i,
	input  wire              write_strobe_n_i,
	input  wire [LANES-1:0]  byte_lane_write_select_n_i,
	input  wire              advance_or_load_i,
	input  wire              chip_select_first_n_i,
	input  wire              chip_select_second_i,
	input  wire              chip_select_third_n_i,
	// Static strap, asynchronous output enable, synchronous sleep request
	input  wire              burst_order_ilv_i,
	input  wire              out_enable_n_i,
	input  wire              sleep_request_i,
	// Data bus, three signals
	input  wire [DATA_W-1:0] dq_i,
	output reg  [DATA_W-1:0] dq_o,
	output wire              dq_oe_o,
	// Status
	output reg               low_power_o
);

	localparam DEPTH = 1 << ADDR_W;

	reg [DATA_W-1:0] mem [0:DEPTH-1]; // R1

	reg              active_reg;
	reg              write_reg;
	reg [ADDR_W-1:0] base_reg;
	reg              wr_pend_reg;
	reg [ADDR_W-1:0] wr_addr_reg;
	reg [LANES-1:0]  wr_bw_n_reg;
	reg              drive_reg;

	// Next values of the control state, worked out in one place.
	reg              active_next;
	reg              write_next;
	reg [ADDR_W-1:0] base_next;
	reg              wr_pend_next;
	reg [ADDR_W-1:0] wr_addr_next;
	reg [LANES-1:0]  wr_bw_n_next;
	reg              drive_next;
	reg [DATA_W-1:0] dq_next;
	reg              low_power_next;

	wire                    qual;
	wire                    selected;
	wire                    load;
	wire                    adv;
	wire                    access;
	wire                    acc_write;
	wire [`FTS_BURST_W-1:0] low;
	wire [ADDR_W-1:0]       acc_addr;
	wire [DATA_W-1:0]       wr_old;
	wire [DATA_W-1:0]       wr_merged;
	wire [DATA_W-1:0]       rd_word;

	assign qual     = ~clock_qualify_n_i; // R3
	assign selected = ~chip_select_first_n_i & chip_select_second_i
		& ~chip_select_third_n_i & ~sleep_request_i; // R9
	// A load with the device selected opens a new access; an advance only
	// continues an access that is already open.
	assign load      = ~advance_or_load_i & selected; // R13
	assign adv       = advance_or_load_i & active_reg & ~sleep_request_i; // R13
	assign access    = load | adv; // R4
	assign acc_write = load ? ~write_strobe_n_i : write_reg; // R14

	fts_burst_ctr u_ctr (
		.mclk_i      (mclk_i),
		.reset_i     (reset_i),
		.qual_i      (qual),
		.load_i      (~advance_or_load_i),
		.adv_i       (adv),
		.order_ilv_i (burst_order_ilv_i),
		.start_i     (addr_i[`FTS_BURST_W-1:0]),
		.low_o       (low)
	);

	assign acc_addr = load ? addr_i : {base_reg[ADDR_W-1:`FTS_BURST_W], low};

	// Write data arrives one cycle after its address; merge the selected lanes.
	assign wr_old = mem[wr_addr_reg];

	genvar l;
	generate
		for (l = 0; l < LANES; l = l + 1) begin : g_lane
			assign wr_merged[l*LANE_W +: LANE_W] = wr_bw_n_reg[l] ?
				wr_old[l*LANE_W +: LANE_W] : dq_i[l*LANE_W +: LANE_W]; // R15
		end
	endgenerate

	// A read of the word being written this edge sees the new lanes.
	assign rd_word = (wr_pend_reg && wr_addr_reg == acc_addr) ? wr_merged : mem[acc_addr];

	// The enable pin gates the drivers directly, with no clock involved.
	assign dq_oe_o = drive_reg & ~out_enable_n_i; // R8

	always @(posedge mclk_i) begin
		if (qual && !reset_i && wr_pend_reg) begin
			mem[wr_addr_reg] <= wr_merged; // R5
		end
	end

	// An unqualified edge leaves every next value equal to its register, so
	// the previous cycle simply stretches and no state moves.
	// Byte selects are taken with the address and applied with the data one
	// qualified edge later, which lets a read follow a write with no gap.
	always @* begin
		active_next    = active_reg;
		write_next     = write_reg;
		base_next      = base_reg;
		wr_pend_next   = wr_pend_reg;
		wr_addr_next   = wr_addr_reg;
		wr_bw_n_next   = wr_bw_n_reg;
		drive_next     = drive_reg;
		dq_next        = dq_o;
		low_power_next = low_power_o;
		if (qual) begin // R3
			low_power_next = sleep_request_i | ~access; // R11
			if (load) begin
				base_next  = addr_i;
				write_next = ~write_strobe_n_i; // R14
			end
			// A deselect or sleep closes the burst; later advances are ignored.
			if (!advance_or_load_i || sleep_request_i) begin
				active_next = load;
			end
			wr_pend_next = access & acc_write; // R4
			wr_addr_next = acc_addr;
			wr_bw_n_next = byte_lane_write_select_n_i; // R5
			drive_next   = access & ~acc_write; // R6 R7
			if (access && !acc_write) begin
				dq_next = rd_word; // R16
			end
		end
	end

	always @(posedge mclk_i) begin
		if (reset_i) begin
			active_reg  <= 1'b0;
			write_reg   <= 1'b0;
			base_reg    <= {ADDR_W{1'b0}};
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= {ADDR_W{1'b0}};
			wr_bw_n_reg <= {LANES{1'b1}};
			drive_reg   <= 1'b0;
			dq_o        <= `FTS_DATA_RST;
			low_power_o <= 1'b1;
		end else begin
			active_reg  <= active_next;
			write_reg   <= write_next;
			base_reg    <= base_next;
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
			wr_bw_n_reg <= wr_bw_n_next;
			drive_reg   <= drive_next;
			dq_o        <= dq_next;
			low_power_o <= low_power_next;
		end
	end

endmodule

// ### tb/fts_host.sv
// Host side of the data wire: resolves the bus from both drivers.
// Assumes the bench raises drv_i only in write data cycles until the freeze checks, and holds it high from then on.
`timescale 1ns/1ns
module fts_host (
	input  wire        mclk_i,
	input  wire [35:0] dq_o,
	input  wire        dq_oe_o,
	input  wire        drv_i,
	input  wire [35:0] wd_i,
	output reg  [35:0] bus_o
);
	reg [35:0] last_reg = 36'h0_0000_0000;
	// A released wire shows the inverse of its last value.
	always @* bus_o = dq_oe_o ? dq_o : drv_i ? wd_i : ~last_reg;
	always @(posedge mclk_i) last_reg <= bus_o;
endmodule

// ### tb/fts_port_chk.sv
// Checker on the memory port pins.
// Assumes binding to fts_port with default widths.
`timescale 1ns/1ns
module fts_port_chk (
	input wire        mclk_i, reset_i, clock_qualify_n_i, write_strobe_n_i,
	input wire        advance_or_load_i, chip_select_first_n_i, chip_select_second_i,
	input wire        chip_select_third_n_i, out_enable_n_i, sleep_request_i,
	input wire [35:0] dq_o,
	input wire        dq_oe_o, low_power_o
);
	wire ld  = !clock_qualify_n_i && !advance_or_load_i;
	wire sel = !chip_select_first_n_i && chip_select_second_i && !chip_select_third_n_i
		&& !sleep_request_i;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	property p_oe; out_enable_n_i |-> !dq_oe_o; endproperty
	a_oe: assert property (p_oe) else $error("driven with enable off");
	property p_frz; clock_qualify_n_i |=> $stable(dq_o) && $stable(low_power_o); endproperty
	a_frz: assert property (p_frz) else $error("state moved while frozen");
	property p_wr; ld && sel && !write_strobe_n_i |=> !dq_oe_o; endproperty
	a_wr: assert property (p_wr) else $error("driven in write data");
	property p_rd; ld && sel && write_strobe_n_i ##1 !out_enable_n_i |-> dq_oe_o; endproperty
	a_rd: assert property (p_rd) else $error("read not driven");
	property p_acc; ld && sel |=> !low_power_o; endproperty
	a_acc: assert property (p_acc) else $error("access not taken");
	property p_dsl; ld && !chip_select_second_i |=> low_power_o && !dq_oe_o; endproperty
	a_dsl: assert property (p_dsl) else $error("deselect ignored");
	property p_slp; !clock_qualify_n_i && sleep_request_i |=> low_power_o; endproperty
	a_slp: assert property (p_slp) else $error("sleep ignored");
	property p_rst; disable iff (1'b0) reset_i |=> !dq_oe_o && low_power_o; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	cover property (ld && sel && !write_strobe_n_i);
	cover property (clock_qualify_n_i);
	cover property (ld && sleep_request_i);
endmodule
bind fts_port fts_port_chk u_chk (.*);

// ### tb/fts_port_bench.sv
// Bench for the memory port: bursts, random merges, freeze, deselect.
// Assumes fts_host resolves the data wire.
`timescale 1ns/1ns
module fts_port_bench;
	reg clk = 0, rst = 1, qn = 0, we = 1, adv = 0, c2 = 1, ilv = 0, oen = 0, slp = 0, drv = 0;
	reg [18:0] a = 0, ba;
	reg [3:0] bw = 0, rb;
	reg [35:0] wd = 0, w, d1;
	wire [35:0] dq, bus;
	wire oe, lp;
	integer fail_count = 0, compares = 0, i, n, s;
	always #50 clk = ~clk;
	fts_port u_dut (.mclk_i(clk), .reset_i(rst), .clock_qualify_n_i(qn), .addr_i(a),
		.write_strobe_n_i(we), .byte_lane_write_select_n_i(bw), .advance_or_load_i(adv),
		.chip_select_first_n_i(1'b0), .chip_select_second_i(c2), .chip_select_third_n_i(1'b0),
		.burst_order_ilv_i(ilv), .out_enable_n_i(oen), .sleep_request_i(slp), .dq_i(bus),
		.dq_o(dq), .dq_oe_o(oe), .low_power_o(lp));
	fts_host u_host (.mclk_i(clk), .dq_o(dq), .dq_oe_o(oe), .drv_i(drv), .wd_i(wd), .bus_o(bus));
	task chk(input [35:0] g, input [35:0] e);
		begin
		compares = compares + 1;
		if (g !== e) begin
			fail_count = fail_count + 1;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
		end
	endtask
	task end_sim;
		begin
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
		end
	endtask
	task cy(input l, input w_n, input [18:0] ad, input [3:0] b, input d, input [35:0] v);
		begin
		@(posedge clk);
		adv <= !l; we <= w_n; a <= ad; bw <= b; drv <= d; wd <= v;
		end
	endtask
	function [35:0] mrg(input [35:0] o, input [35:0] v, input [3:0] b);
		integer k;
		begin
		mrg = o;
		for (k = 0; k < 4; k = k + 1) if (!b[k]) mrg[9*k+:9] = v[9*k+:9];
		end
	endfunction
	function [18:0] sq(input [18:0] st, input [1:0] j, input o);
		sq = {st[18:2], o ? st[1:0] ^ j : st[1:0] + j};
	endfunction
	initial begin
		s = $urandom(32'h8a9edc92);
		repeat (3) @(posedge clk);
		rst <= 0;
		for (n = 0; n < 2; n = n + 1) begin
			ilv <= n;
			ba = $urandom;
			for (i = 0; i < 9; i = i + 1) begin
				cy(i % 4 == 0, i > 3, i < 4 ? ba : ba ^ 19'h1, 0, i > 0 && i < 5,
					{17'h0, sq(ba, i - 1, n)});
				#1 if (i > 4) chk(dq, {17'h0, sq(ba ^ 19'h1, i - 5, n)});
			end
		end
		repeat (20) begin
			ba = $urandom; rb = $urandom; w = {$urandom, $urandom}; d1 = {$urandom, $urandom};
			cy(1, 0, ba, 0, 0, 0);
			cy(1, 0, ba, rb, 1, w);
			cy(1, 1, ba, 0, 1, d1);
			cy(0, 1, ba, 0, 0, 0);
			#1 chk(dq, mrg(w, d1, rb));
		end
		@(posedge clk) qn <= 1;
		#1 w = dq;
		cy(1, 0, 0, 0, 1, 0);
		cy(1, 0, 1, 0, 1, 0);
		#1 chk(dq, w);
		#1 chk(oe, 1);
		@(posedge clk) oen <= 1;
		#1 chk(oe, 0);
		@(posedge clk) qn <= 0;
		oen <= 0; c2 <= 0;
		@(posedge clk) #1 chk(lp, 1);
		@(posedge clk) c2 <= 1;
		slp <= 1;
		@(posedge clk) #1 chk(lp, 1);
		end_sim;
	end
	initial begin
		#100000;
		fail_count = fail_count + 1;
		end_sim;
	end
endmodule
